// file: rtl/oswc_pkg.sv
// constants and types for the on/off switch controller
package oswc_pkg;
  // clock and oscillator timing
  localparam int SYS_HZ      = 25_000_000;
  localparam int OSC_HZ      = 132_000;
  localparam int JIT_PP_HZ   = 8_000;
  localparam int JIT_RATE_HZ = 1_000;
  localparam int PER_MIN     = SYS_HZ / (OSC_HZ + JIT_PP_HZ / 2);
  localparam int PER_MAX     = SYS_HZ / (OSC_HZ - JIT_PP_HZ / 2);
  localparam int JIT_SPAN    = PER_MAX - PER_MIN;
  localparam int JIT_STEP    = SYS_HZ / (JIT_RATE_HZ * 2 * JIT_SPAN);
  // max duty cycle in percent of the shortest period
  localparam int DUTY_PCT    = 65;
  localparam int MAX_ON      = PER_MIN * DUTY_PCT / 100;
  // leading edge blanking, rounded up to whole cycles
  localparam int LEB_NS      = 200;
  localparam int LEB_CYC     = (LEB_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
  // auto-restart intervals in oscillator cycles
  localparam int WATCH_MS    = 50;
  localparam int OFF_MS      = 850;
  localparam int WATCH_CYC   = WATCH_MS * (OSC_HZ / 1000);
  localparam int OFF_CYC     = OFF_MS * (OSC_HZ / 1000);
  // load inference over the last HIST_LEN enable samples
  localparam int HIST_LEN    = 8;
  localparam int HIST_FULL   = 6;
  localparam int HIST_MED    = 3;
  // widths
  localparam int CNT_W       = 8;
  localparam int JIT_W       = 4;
  localparam int JTMR_W      = 11;
  localparam int LEB_W       = 4;
  localparam int AR_W        = 17;
  // reset values
  localparam logic UVLO_RST  = 1'b1;
  localparam logic OTP_RST   = 1'b0;

  typedef enum logic [1:0] {LIM_FULL, LIM_MED, LIM_LIGHT} oswc_lim_t;
  typedef enum logic {AR_RUN, AR_OFF} oswc_ar_t;

  // digital comparator flags from the analog front end
  typedef struct packed {
    logic en_high;     // current out of the enable pin below trip
    logic ilim_hit;    // switch current above active threshold
    logic bp_below_lo; // internal supply below low threshold
    logic bp_above_hi; // internal supply back at regulation level
    logic temp_hot;    // die above shutdown threshold
    logic temp_cooled; // die has fallen by the hysteresis
    logic line_low;    // current into enable pin below line trip
    logic no_resistor; // no line sense resistor present
  } oswc_sense_t;

  typedef struct packed {
    logic      switch_on;
    logic      cycle_start;
    logic      max_duty_limit;
    oswc_lim_t current_limit_threshold;
    logic      bypass_hold_low;
    logic      switching_allowed;
  } oswc_drive_t;
endpackage : oswc_pkg

// file: rtl/oswc_top.sv
// on/off switch control logic: oscillator, enable, limit, protections
// Contract
// [R1] oscillator near 132 kHz gives cycle start and max duty limit
// [R2] period jitters about 8 kHz peak-to-peak, sweeping at 1 kHz
// [R3] enable level low when current out of enable pin exceeds trip
// [R4] enable sampled at cycle start; high turns switch on for cycle
// [R5] enable changes after cycle start ignored until next start
// [R6] limit state machine lowers threshold stepwise at lighter loads
// [R7] current above limit turns switch off for rest of cycle
// [R8] limit comparator blanked for a short time after turn-on
// [R9] switch off at current limit or max duty, whichever first
// [R10] supply lockout below 4.8 V, released only at 5.8 V
// [R11] thermal shutdown above 135 C, re-enabled after 70 C drop
// [R12] auto-restart counter cleared whenever enable is pulled low; code clears it in the run state only, not during the off time
// [R13] 50 ms without enable low disables switching for 850 ms
// [R14] auto-restart alternates on and off while fault persists
// [R15] line under-voltage halts counter during auto-restart off time
// [R16] start and restart need line current above the start trip
// [R17] supply held at low level during power-up line under-voltage
// [R18] no line resistor detected disables line under-voltage function
// [R19] secondary drives enable high below reference, low above it
// [R20] enabled cycle uses full or reduced limit chosen by state machine
// [R21] comparator flags synchronised to the clock before use
// [R22] restart counter wide enough for watch and off intervals
`timescale 1ns/1ps
`default_nettype none
module oswc_top #(
  parameter int WATCH_CYC = oswc_pkg::WATCH_CYC,
  parameter int OFF_CYC   = oswc_pkg::OFF_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire oswc_pkg::oswc_sense_t sense_in,
  output var  oswc_pkg::oswc_drive_t drive_out,
  output logic                     uvlo_active,
  output logic                     otp_active,
  output logic                     auto_restart_off
);

  typedef struct packed {
    oswc_pkg::oswc_sense_t       s1;
    oswc_pkg::oswc_sense_t       s2;
    logic [oswc_pkg::CNT_W-1:0]  phase;
    logic [oswc_pkg::CNT_W-1:0]  per;
    logic [oswc_pkg::JIT_W-1:0]  jit;
    logic                        jit_up;
    logic [oswc_pkg::JTMR_W-1:0] jtmr;
    logic                        cs;
    logic                        dmax;
    logic                        on;
    logic [oswc_pkg::LEB_W-1:0]  blank;
    logic [oswc_pkg::HIST_LEN-1:0] hist;
    oswc_pkg::oswc_lim_t         lvl;
    oswc_pkg::oswc_ar_t          ar;
    logic [oswc_pkg::AR_W-1:0]   ar_cnt; // R22
    logic                        uvlo;
    logic                        otp;
    logic                        started;
  } oswc_state_t;

  oswc_state_t s_q;
  oswc_state_t s_d;

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : ones8

  // synchronised flags, only second stage is used
  logic en_s;
  logic ilim_s;
  logic line_uv;
  logic allow;
  logic cyc_end;
  logic [3:0] hist_n;

  assign en_s    = s_q.s2.en_high; // R3 R21
  assign ilim_s  = s_q.s2.ilim_hit;
  // R18: without a sense resistor the line check never blocks
  assign line_uv = s_q.s2.line_low & ~s_q.s2.no_resistor; // R18
  assign allow   = s_q.started & ~s_q.uvlo & ~s_q.otp
                   & (s_q.ar == oswc_pkg::AR_RUN);
  assign cyc_end = (s_q.phase == s_q.per - 8'h01);

  always_comb begin
    s_d    = s_q;
    hist_n = 4'h0;
    s_d.s1 = sense_in; // R21
    s_d.s2 = s_q.s1;   // R21
    s_d.cs = 1'b0;

    // jitter sweep: triangle over the period offset
    if (s_q.jtmr == oswc_pkg::JTMR_W'(oswc_pkg::JIT_STEP - 1)) begin
      s_d.jtmr = '0;
      if (s_q.jit_up) begin // R2
        s_d.jit = s_q.jit + 4'h1;
        if (s_q.jit == oswc_pkg::JIT_W'(oswc_pkg::JIT_SPAN - 1)) begin
          s_d.jit_up = 1'b0;
        end
      end else begin
        s_d.jit = s_q.jit - 4'h1;
        if (s_q.jit == 4'h1) begin
          s_d.jit_up = 1'b1;
        end
      end
    end else begin
      s_d.jtmr = s_q.jtmr + 11'h001;
    end

    // oscillator phase, period picked up at each cycle start
    if (cyc_end) begin // R1
      s_d.phase = '0;
      s_d.per   = oswc_pkg::CNT_W'(oswc_pkg::PER_MIN) + {4'h0, s_q.jit};
      s_d.cs    = 1'b1;
    end else begin
      s_d.phase = s_q.phase + 8'h01;
    end
    s_d.dmax = (s_d.phase < oswc_pkg::CNT_W'(oswc_pkg::MAX_ON)); // R1

    // on-time: terminate on current limit or max duty
    if (s_q.blank != '0) begin
      s_d.blank = s_q.blank - 4'h1;
    end
    if (s_q.on) begin
      if (ilim_s && s_q.blank == '0) begin // R7 R8 R9
        s_d.on = 1'b0;
      end else if (!s_d.dmax) begin // R9
        s_d.on = 1'b0;
      end
    end
    if (!allow) begin
      s_d.on = 1'b0;
    end

    // cycle start: one sample of enable decides the whole cycle
    if (cyc_end) begin // R4 R5
      s_d.hist = {s_q.hist[oswc_pkg::HIST_LEN-2:0], en_s};
      hist_n   = ones8(s_d.hist);
      // R6 R20: more skipped cycles mean lighter load, lower limit
      if (hist_n >= 4'(oswc_pkg::HIST_FULL)) begin // R6
        s_d.lvl = oswc_pkg::LIM_FULL;
      end else if (hist_n >= 4'(oswc_pkg::HIST_MED)) begin
        s_d.lvl = oswc_pkg::LIM_MED;
      end else begin
        s_d.lvl = oswc_pkg::LIM_LIGHT;
      end
      if (en_s && allow) begin // R4 R20
        s_d.on    = 1'b1;
        s_d.blank = oswc_pkg::LEB_W'(oswc_pkg::LEB_CYC); // R8
      end else begin
        s_d.on = 1'b0;
      end
    end

    // supply lockout, set wins over release
    if (s_q.s2.bp_below_lo) begin // R10
      s_d.uvlo = 1'b1;
    end else if (s_q.s2.bp_above_hi) begin
      s_d.uvlo = 1'b0;
    end
    if (s_q.s2.temp_hot) begin // R11
      s_d.otp = 1'b1;
    end else if (s_q.s2.temp_cooled) begin
      s_d.otp = 1'b0;
    end

    // first start waits for the line and the supply
    if (!s_q.started && !line_uv && !s_q.uvlo) begin // R16 R17
      s_d.started = 1'b1;
    end

    // auto-restart counts oscillator cycles
    case (s_q.ar)
      oswc_pkg::AR_RUN: begin
        if (!en_s) begin // R12
          s_d.ar_cnt = '0;
        end else if (cyc_end) begin
          if (s_q.ar_cnt == oswc_pkg::AR_W'(WATCH_CYC - 1)) begin // R13
            s_d.ar     = oswc_pkg::AR_OFF;
            s_d.ar_cnt = '0;
            s_d.on     = 1'b0;
          end else begin
            s_d.ar_cnt = s_q.ar_cnt + 17'h0_0001;
          end
        end
      end
      oswc_pkg::AR_OFF: begin
        // the count freezes while the line is low, stretching the off time
        if (cyc_end && !line_uv) begin // R15
          if (s_q.ar_cnt >= oswc_pkg::AR_W'(OFF_CYC - 1)) begin // R13 R14
            s_d.ar     = oswc_pkg::AR_RUN; // R16
            s_d.ar_cnt = '0;
          end else begin
            s_d.ar_cnt = s_q.ar_cnt + 17'h0_0001;
          end
        end
      end
      default: begin
        s_d.ar = oswc_pkg::AR_RUN;
      end
    endcase
  end

  // reset holds the lockout set, so no pulse before the supply is seen good
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.per     <= oswc_pkg::CNT_W'(oswc_pkg::PER_MIN);
      s_q.jit_up  <= 1'b1;
      s_q.lvl     <= oswc_pkg::LIM_FULL;
      s_q.ar      <= oswc_pkg::AR_RUN;
      s_q.uvlo    <= oswc_pkg::UVLO_RST;
      s_q.otp     <= oswc_pkg::OTP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign drive_out.switch_on               = s_q.on;
  assign drive_out.cycle_start             = s_q.cs;
  assign drive_out.max_duty_limit          = s_q.dmax;
  assign drive_out.current_limit_threshold = s_q.lvl;
  assign drive_out.bypass_hold_low         = ~s_q.started & line_uv; // R17
  assign drive_out.switching_allowed       = allow;
  assign uvlo_active      = s_q.uvlo;
  assign otp_active       = s_q.otp;
  assign auto_restart_off = (s_q.ar == oswc_pkg::AR_OFF);

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_on_at_start: assert property ( // R4
    $rose(s_q.on) |-> s_q.cs && $past(en_s))
    else $error("switch turned on outside a sampled cycle start");
  a_ilim_off: assert property ( // R7
    s_q.on && ilim_s && s_q.blank == '0 |=> !s_q.on)
    else $error("switch stayed on past current limit");
  a_blank_hold: assert property ( // R8
    s_q.on && s_q.blank != '0 && allow && !s_d.cs |=> s_q.on)
    else $error("pulse ended inside blanking");
  a_dmax_bound: assert property ( // R9
    !s_q.dmax |-> !s_q.on)
    else $error("switch on beyond max duty");
  a_no_restart_mid: assert property ( // R5
    !cyc_end |=> !$rose(s_q.on))
    else $error("switch started mid cycle");
  a_uvlo_gate: assert property ( // R10
    s_q.uvlo |=> !s_q.on)
    else $error("switching under supply lockout");
  a_uvlo_release: assert property ( // R10
    $fell(s_q.uvlo) |-> $past(s_q.s2.bp_above_hi)
                        && !$past(s_q.s2.bp_below_lo))
    else $error("lockout released without supply recovery");
  a_otp_gate: assert property ( // R11
    s_q.otp |=> !s_q.on)
    else $error("switching during thermal shutdown");
  a_ar_clear: assert property ( // R12
    s_q.ar == oswc_pkg::AR_RUN && !en_s |=> s_q.ar_cnt == '0)
    else $error("restart counter not cleared by enable low");
  a_ar_freeze: assert property ( // R15
    s_q.ar == oswc_pkg::AR_OFF && line_uv |=> $stable(s_q.ar_cnt))
    else $error("restart counter ran during line under-voltage");
  a_period_range: assert property ( // R2
    s_q.cs |-> s_q.per >= oswc_pkg::CNT_W'(oswc_pkg::PER_MIN)
               && s_q.per <= oswc_pkg::CNT_W'(oswc_pkg::PER_MAX))
    else $error("oscillator period out of jitter range");

  // restart sequencing: entry only from a full watch, no pulse while off
  a_ar_watch: assert property ( // R13
    $rose(s_q.ar == oswc_pkg::AR_OFF) |-> s_q.cs
    && $past(s_q.ar_cnt) == oswc_pkg::AR_W'(WATCH_CYC - 1))
    else $error("restart off time entered before watch expiry");
  a_off_gate: assert property ( // R13
    s_q.ar == oswc_pkg::AR_OFF |-> !s_q.on)
    else $error("switch on during restart off time");
  a_line_hold: assert property ( // R16
    !s_q.started && line_uv |=> !s_q.started)
    else $error("first start taken during line under-voltage");
  a_start_gate: assert property ( // R16
    !s_q.started |-> !s_q.on)
    else $error("switch on before first start");
  a_dmax_window: assert property ( // R1
    s_q.cs |-> s_q.dmax)
    else $error("max duty window closed at cycle start");
  a_lim_update: assert property ( // R6
    $changed(s_q.lvl) |-> s_q.cs)
    else $error("limit level changed outside a cycle start");

  c_switch_cycle: cover property ($rose(s_q.on) ##[1:200] $fell(s_q.on));
  c_ilim_end: cover property (s_q.on && ilim_s && s_q.blank == '0);
  c_ar_enter: cover property ($rose(s_q.ar == oswc_pkg::AR_OFF));
  c_light_load: cover property (s_q.lvl == oswc_pkg::LIM_LIGHT);
  // leaving the off period shows the restart loop closes again
  c_ar_exit: cover property ($fell(s_q.ar == oswc_pkg::AR_OFF));

endmodule : oswc_top
`default_nettype wire

// file: testbench/oswc_fb_model.sv
// feedback partner: secondary output integrator with reference compare
`timescale 1ns/1ps
`default_nettype none
module oswc_fb_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       switch_on,
  input  wire logic [3:0] load,
  input  wire logic       open_loop,
  output logic            en_high
);
  int v;
  // open loop stands for a broken opto path that never pulls low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      v <= 0;
    end else if (open_loop) begin
      v <= 0;
    end else begin
      v <= v + (switch_on ? 4 : 0) - (v > 15 ? int'(load) : 0);
    end
  end
  assign en_high = open_loop | (v < 1000);
endmodule : oswc_fb_model
`default_nettype wire

// file: testbench/tb_top.sv
// top testbench: drives sense flags and checks the switch drive
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // short restart counts keep the run near 62k clocks
  localparam int WC  = 20;
  localparam int OC  = 40;
  localparam int PMN = oswc_pkg::PER_MIN;
  localparam int PMX = oswc_pkg::PER_MAX;
  localparam int MXO = oswc_pkg::MAX_ON;
  localparam int LEB = oswc_pkg::LEB_CYC;
  logic sys_clk, rst_n, use_fb, open_loop, fb_en, e, uvlo, otp, aro;
  logic [3:0]            load;
  logic [7:0]            h;
  oswc_pkg::oswc_sense_t s;
  oswc_pkg::oswc_sense_t sense_in;
  oswc_pkg::oswc_drive_t d;
  int err_total = 0, checks = 0, t = 0, last = 0, pmin = 999, pmax = 0;
  int i, j, l, n, p;
  always_comb begin
    sense_in = s;
    sense_in.en_high = use_fb ? fb_en : s.en_high;
  end
  oswc_top #(.WATCH_CYC(WC), .OFF_CYC(OC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .sense_in(sense_in), .drive_out(d),
    .uvlo_active(uvlo), .otp_active(otp), .auto_restart_off(aro));
  oswc_fb_model i_fb (
    .sys_clk(sys_clk), .rst_n(rst_n), .switch_on(d.switch_on), .load(load),
    .open_loop(open_loop), .en_high(fb_en));
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // ends 1 ns past the edge so the design's updates have landed
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic nxt;
    int c;
    for (c = 0; c < 400; c++) begin
      cyc(1);
      if (d.cycle_start === 1'h1) break;
    end
    chk(c < 400, "no cycle start");
  endtask : nxt
  task automatic onlen;
    for (l = 0; l < 300 && d.switch_on === 1'h1; l++) cyc(1);
  endtask : onlen
  task automatic quiet(input int c, input string m);
    n = 0;
    repeat (c) begin
      cyc(1);
      if (d.switch_on === 1'h1) n++;
    end
    chk(n == 0, m);
  endtask : quiet
  function automatic oswc_pkg::oswc_lim_t lim_of(input logic [7:0] v);
    int c;
    c = $countones(v);
    if (c >= oswc_pkg::HIST_FULL) return oswc_pkg::LIM_FULL;
    if (c >= oswc_pkg::HIST_MED) return oswc_pkg::LIM_MED;
    return oswc_pkg::LIM_LIGHT;
  endfunction : lim_of
  // period watch; the first start after reset only sets the mark
  always @(posedge sys_clk) begin
    t++;
    if (!rst_n) begin
      last = 0;
    end else if (d.cycle_start === 1'h1) begin
      p = t - last;
      if (last > 0) chk(p >= PMN && p <= PMX, "period");
      if (last > 0 && p < pmin) pmin = p;
      if (last > 0 && p > pmax) pmax = p;
      last = t;
    end
  end
  initial begin
    s = '0;
    s.en_high = 1'h1;
    s.line_low = 1'h1;
    rst_n = 1'h0;
    use_fb = 1'h0;
    open_loop = 1'h0;
    load = 4'h1;
    l = $urandom(32'h0000_881c);
    cyc(16);
    chk(uvlo === 1'h1 && otp === 1'h0 && aro === 1'h0, "reset");
    chk(d.switch_on === 1'h0, "reset drive");
    rst_n <= 1'h1;
    quiet(400, "switched in lockout");
    s.bp_above_hi <= 1'h1;
    cyc(4);
    s.bp_above_hi <= 1'h0;
    cyc(4);
    chk(uvlo === 1'h0, "lockout kept");
    chk(d.bypass_hold_low === 1'h1, "no supply hold");
    quiet(400, "started in line uv");
    s.no_resistor <= 1'h1;
    nxt;
    nxt;
    chk(d.switch_on === 1'h1, "no start without resistor");
    s.line_low <= 1'h0;
    s.no_resistor <= 1'h0;
    h = '0;
    // every eighth sample low so the restart watch never expires here
    for (i = 0; i < 40; i++) begin
      e = (i % 8 == 7) ? 1'h0 : 1'($urandom % 2);
      s.en_high <= e;
      nxt;
      chk(d.switch_on === e, "enable sample");
      s.en_high <= ~e;
      h = {h[6:0], e};
      cyc(2);
      if (i > 7) chk(d.current_limit_threshold === lim_of(h), "lim");
      cyc(60);
      chk(d.switch_on === e, "mid-cycle change");
    end
    nxt;
    chk(d.max_duty_limit === 1'h1, "duty flag low");
    onlen;
    chk(l >= MXO - 1 && l <= MXO + 1, "max duty");
    chk(d.max_duty_limit === 1'h0, "duty flag high");
    s.ilim_hit <= 1'h1;
    nxt;
    onlen;
    chk(l >= LEB + 1 && l <= LEB + 4, "blanking");
    s.ilim_hit <= 1'h0;
    cyc(80);
    chk(d.switch_on === 1'h0, "restarted in cycle");
    nxt;
    cyc(40);
    chk(d.switch_on === 1'h1, "pulse lost");
    s.ilim_hit <= 1'h1;
    cyc(5);
    chk(d.switch_on === 1'h0, "limit missed");
    s.ilim_hit <= 1'h0;
    for (j = 0; j < 2; j++) begin
      nxt;
      cyc(20);
      s[5 - 2 * j] <= 1'h1;
      cyc(5);
      chk(d.switch_on === 1'h0 && (j ? otp : uvlo) === 1'h1, "trip");
      chk(d.switching_allowed === 1'h0, "allowed while tripped");
      s[5 - 2 * j] <= 1'h0;
      quiet(400, "switched while tripped");
      s[4 - 2 * j] <= 1'h1;
      cyc(4);
      s[4 - 2 * j] <= 1'h0;
      cyc(4);
      chk((j ? otp : uvlo) === 1'h0, "not released");
      chk(d.switching_allowed === 1'h1, "still blocked");
    end
    for (i = 0; i < 51; i++) begin
      s.en_high <= (i % 10 != 0);
      nxt;
    end
    chk(aro === 1'h0, "restart despite enable low");
    use_fb <= 1'h1;
    open_loop <= 1'h1;
    for (n = 0; n < 60 && aro !== 1'h1; n++) nxt;
    chk(n >= WC - 2 && n <= WC + 1, "watch time");
    for (i = 0; i < 300 && aro === 1'h1; i++) begin
      s.line_low <= (i >= 10 && i < 70);
      chk(d.switch_on === 1'h0, "switched in off time");
      nxt;
    end
    chk(i >= OC + 57 && i <= OC + 63, "off time");
    nxt;
    nxt;
    chk(d.switch_on === 1'h1, "no restart");
    for (n = 2; n < 60 && aro !== 1'h1; n++) nxt;
    chk(n >= WC - 2 && n <= WC + 1, "second watch");
    open_loop <= 1'h0;
    for (i = 0; i < 300 && aro === 1'h1; i++) nxt;
    n = 0;
    for (i = 0; i < 40; i++) begin
      nxt;
      if (d.switch_on === 1'h1) n++;
    end
    chk(n > 2 && n < 40 && aro === 1'h0, "no regulation");
    chk(d.current_limit_threshold !== oswc_pkg::LIM_FULL, "light");
    chk(pmin <= PMN + 1 && pmax >= PMX - 1, "no jitter");
    stop_test;
  end
  initial begin
    cyc(100000);
    err_total++;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
